/* File: smsc_ctrl.sv */
// top: hardware standby, module stop, all-clocks-stop and clock pin control
// Contract
// - standby pin low enters hardware standby
// - standby: reset all, hold RAM, pins hi-z
// - standby high, reset low: reset, oscillator on
// - reset rise runs reset exception, then program
// - stop bit one halts peripheral at cycle end
// - stop bit zero resumes peripheral at cycle end
// - stopped peripherals keep state except serial
// - after reset only transfer engines run
// - stopped peripheral register access has no effect
// - sleep with conditions stops all but timer8, watchdog
// - lowest stop bit gates timer8 in all-stop
// - interrupts or reset end all-clocks-stop
// - masked or transfer-assigned wakeups do not end it
// - clock-out stop bit holds pin high
// - direction zero makes clock pin hi-z
// - clock pin drive per state table
// - sleep with standby select zero: sleep or all-stop
module smsc_ctrl (
  // ahb-lite
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // pins
  input  wire logic        standby_pin_n,
  input  wire logic        reset_pin_n,
  input  wire logic [2:0]  op_mode_select_pins,
  input  wire logic        nmi_pin,
  input  wire logic [15:0] ext_interrupt_pins,
  // cpu side
  input  wire logic        sleep_req,
  input  wire logic        irq_enabled,
  input  wire logic        irq_masked_but_nmi,
  input  wire logic        wake_is_dtc_source,
  input  wire logic        tmr8_irq,
  input  wire logic        wdt_irq,
  input  wire logic        cpu_bus_busy,
  input  wire logic [2:0]  xfer_engine_active,
  // peripheral and chip controls
  output logic [15:0]      periph_clk_en,
  output logic [15:0]      periph_rst,
  output logic [15:0]      periph_access_en,
  output logic             chip_reset,
  output logic             osc_enable,
  output logic             reset_exc_start,
  output logic             cpu_run,
  output logic             wake_exc_start,
  output logic             ports_hiz,
  output logic             bus_io_stop,
  output logic             ram_enable_bit,
  output logic [2:0]       op_mode_latched,
  // system clock pin
  output logic             clk_pin_o,
  output logic             clk_pin_oe
);
  smsc_pkg::smsc_state_t state_q;
  logic [15:0] module_stop_control_reg;
  logic [15:0] mstop_req_q;
  logic [4:0]  syscfg_q;
  logic        clock_out_stop_bit_act_q;
  logic        standby_pin_n_n_s, res_n_s, nmi_s;
  logic [15:0] irq_s;
  logic [15:0] osc_cnt_q;
  logic        ph_q, hw_q, rd_q;
  logic [7:0]  ad_q;
  logic        div_q;
  logic [2:0]  mode_s;

  smsc_sync #(.W(1), .INIT(1'b0)) u_standby_pin_n (.clk(hclk), .rst_n(hresetn),
    .d(standby_pin_n), .q(standby_pin_n_n_s));
  smsc_sync #(.W(1), .INIT(1'b0)) u_res (.clk(hclk), .rst_n(hresetn),
    .d(reset_pin_n), .q(res_n_s));
  smsc_sync #(.W(17), .INIT(17'h0_0000)) u_irq (.clk(hclk), .rst_n(hresetn),
    .d({nmi_pin, ext_interrupt_pins}), .q({nmi_s, irq_s}));
  smsc_sync #(.W(3), .INIT(3'h0)) u_mode (.clk(hclk), .rst_n(hresetn),
    .d(op_mode_select_pins), .q(mode_s));

  // wake qualification
  logic wake_src, wake_ok, sleep_go, acs_cond;
  assign wake_src = nmi_s | (|irq_s) | tmr8_irq | wdt_irq;
  assign wake_ok  = nmi_s | (wake_src & irq_enabled & ~irq_masked_but_nmi
                    & ~wake_is_dtc_source);
  assign acs_cond = syscfg_q[smsc_pkg::BIT_ALL_CLOCKS_STOP_ENABLE] &
                    (module_stop_control_reg == smsc_pkg::MSTOP_ALL |
                     module_stop_control_reg == smsc_pkg::MSTOP_NT8);
  assign sleep_go = sleep_req & ~cpu_bus_busy;

  // power state machine
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= smsc_pkg::SMSC_HWSTBY;
    end else if (!standby_pin_n_n_s) begin
      state_q <= smsc_pkg::SMSC_HWSTBY;
    end else begin
      unique case (state_q)
        smsc_pkg::SMSC_HWSTBY: begin
          if (!res_n_s) state_q <= smsc_pkg::SMSC_RESET;
        end
        smsc_pkg::SMSC_RESET: begin
          if (res_n_s && osc_cnt_q == 16'h0000)
            state_q <= smsc_pkg::SMSC_RSTEX;
        end
        smsc_pkg::SMSC_RSTEX: begin
          state_q <= smsc_pkg::SMSC_RUN;
        end
        smsc_pkg::SMSC_RUN: begin
          if (!res_n_s) state_q <= smsc_pkg::SMSC_RESET;
          else if (sleep_go && syscfg_q[smsc_pkg::BIT_SOFT_STANDBY_SELECT])
            state_q <= smsc_pkg::SMSC_SWSTBY;
          else if (sleep_go && acs_cond)
            state_q <= smsc_pkg::SMSC_ACSTOP;
          else if (sleep_go)
            state_q <= smsc_pkg::SMSC_SLEEP;
        end
        smsc_pkg::SMSC_SLEEP, smsc_pkg::SMSC_ACSTOP: begin
          if (!res_n_s) state_q <= smsc_pkg::SMSC_RESET;
          else if (wake_ok) state_q <= smsc_pkg::SMSC_RUN;
        end
        smsc_pkg::SMSC_SWSTBY: begin
          if (!res_n_s) state_q <= smsc_pkg::SMSC_RESET;
          else if (nmi_s || (|irq_s)) state_q <= smsc_pkg::SMSC_RUN;
        end
        default: state_q <= smsc_pkg::SMSC_HWSTBY;
      endcase
    end
  end

  // oscillator start count, runs in reset state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_cnt_q <= 16'(smsc_pkg::OSC_CYC);
    end else if (state_q == smsc_pkg::SMSC_HWSTBY) begin
      osc_cnt_q <= 16'(smsc_pkg::OSC_CYC);
    end else if (state_q == smsc_pkg::SMSC_RESET && osc_cnt_q != 16'h0000) begin
      osc_cnt_q <= osc_cnt_q - 16'h0001;
    end
  end

  // mode pins caught while standby releases
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_mode_latched <= 3'h0;
    end else if (state_q == smsc_pkg::SMSC_HWSTBY) begin
      op_mode_latched <= mode_s;
    end
  end

  // ahb-lite slave
  logic in_reset, wr_ok, rd_en;
  assign in_reset = state_q == smsc_pkg::SMSC_HWSTBY || state_q == smsc_pkg::SMSC_RESET;
  assign rd_en = hsel & hready & htrans[1] & ~hwrite;
  assign wr_ok = ph_q & hw_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_q <= 1'b0;
      hw_q <= 1'b0;
      rd_q <= 1'b0;
      ad_q <= 8'h00;
    end else if (hready) begin
      ph_q <= hsel & htrans[1];
      hw_q <= hsel & htrans[1] & hwrite;
      rd_q <= rd_en;
      ad_q <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // software registers, held in reset during standby and reset states
  logic [15:0] mstop_wr;
  always_comb begin
    mstop_wr = hwdata[15:0];
    for (int i = smsc_pkg::BIT_XFER_LO; i <= smsc_pkg::BIT_XFER_HI; i++) begin
      if (xfer_engine_active[i - smsc_pkg::BIT_XFER_LO] && !mstop_req_q[i])
        mstop_wr[i] = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mstop_req_q <= smsc_pkg::MSTOP_RST;
    end else if (in_reset) begin
      mstop_req_q <= smsc_pkg::MSTOP_RST;
    end else if (wr_ok && ad_q == smsc_pkg::OFS_MSTOP) begin
      mstop_req_q <= mstop_wr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      syscfg_q <= smsc_pkg::SYSCFG_RST;
    end else if (in_reset) begin
      syscfg_q <= smsc_pkg::SYSCFG_RST;
    end else if (wr_ok && ad_q == smsc_pkg::OFS_SYSCFG) begin
      syscfg_q <= hwdata[4:0];
    end
  end

  // applied only once no bus transfer is in flight
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      module_stop_control_reg <= smsc_pkg::MSTOP_RST;
      clock_out_stop_bit_act_q             <= 1'b0;
    end else if (in_reset) begin
      module_stop_control_reg <= smsc_pkg::MSTOP_RST;
      clock_out_stop_bit_act_q             <= 1'b0;
    end else if (!cpu_bus_busy && !ph_q) begin
      module_stop_control_reg <= mstop_req_q;
      clock_out_stop_bit_act_q             <= syscfg_q[smsc_pkg::BIT_CLOCK_OUT_STOP_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_en) begin
      unique case (haddr)
        smsc_pkg::OFS_MSTOP:  hrdata <= {16'h0000, mstop_req_q};
        smsc_pkg::OFS_SYSCFG: hrdata <= {27'h000_0000, syscfg_q};
        smsc_pkg::OFS_STATUS: hrdata <= {13'h0000, state_q, module_stop_control_reg};
        default:              hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // peripheral enables
  logic [15:0] run_mask;
  always_comb begin
    run_mask = ~module_stop_control_reg;
    if (state_q == smsc_pkg::SMSC_ACSTOP)
      run_mask = {15'h0000, ~module_stop_control_reg[smsc_pkg::BIT_TMR8]};
    if (in_reset || state_q == smsc_pkg::SMSC_SWSTBY)
      run_mask = 16'h0000;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      periph_clk_en    <= 16'h0000;
      periph_access_en <= 16'h0000;
      periph_rst       <= 16'hFFFF;
    end else begin
      periph_clk_en    <= run_mask;
      periph_access_en <= run_mask;
      for (int i = 0; i < smsc_pkg::NMOD; i++) begin
        // serial interface loses state when stopped, others keep it
        periph_rst[i] <= in_reset ||
          (i == smsc_pkg::BIT_SCI && module_stop_control_reg[i]);
      end
    end
  end

  // chip controls
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chip_reset      <= 1'b1;
      osc_enable      <= 1'b0;
      reset_exc_start <= 1'b0;
      cpu_run         <= 1'b0;
      wake_exc_start  <= 1'b0;
      ports_hiz       <= 1'b1;
      bus_io_stop     <= 1'b0;
      ram_enable_bit  <= 1'b1;
    end else begin
      chip_reset      <= in_reset;
      osc_enable      <= state_q != smsc_pkg::SMSC_HWSTBY &&
                         state_q != smsc_pkg::SMSC_SWSTBY;
      reset_exc_start <= state_q == smsc_pkg::SMSC_RSTEX;
      cpu_run         <= state_q == smsc_pkg::SMSC_RUN;
      wake_exc_start  <= (state_q == smsc_pkg::SMSC_SLEEP ||
                          state_q == smsc_pkg::SMSC_ACSTOP) &&
                         standby_pin_n_n_s && res_n_s && wake_ok;
      ports_hiz       <= state_q == smsc_pkg::SMSC_HWSTBY;
      bus_io_stop     <= state_q == smsc_pkg::SMSC_ACSTOP;
      ram_enable_bit  <= syscfg_q[smsc_pkg::BIT_RAM_ENABLE_BIT];
    end
  end

  // system clock pin, divided by two from hclk
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q      <= 1'b0;
      clk_pin_o  <= 1'b1;
      clk_pin_oe <= 1'b0;
    end else begin
      div_q <= ~div_q;
      if (state_q == smsc_pkg::SMSC_HWSTBY || !syscfg_q[smsc_pkg::BIT_DDR]) begin
        clk_pin_oe <= 1'b0;
        clk_pin_o  <= 1'b1;
      end else if (clock_out_stop_bit_act_q || state_q == smsc_pkg::SMSC_SWSTBY) begin
        clk_pin_oe <= 1'b1;
        clk_pin_o  <= 1'b1;
      end else begin
        clk_pin_oe <= 1'b1;
        clk_pin_o  <= div_q;
      end
    end
  end

  // assertions
  a_standby_pin_n_enter: assert property (@(posedge hclk) disable iff (!hresetn)
    !standby_pin_n_n_s |=> state_q == smsc_pkg::SMSC_HWSTBY) else $error("standby not entered");
  a_standby_pin_n_hiz: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == smsc_pkg::SMSC_HWSTBY |=> ports_hiz && chip_reset && !clk_pin_oe)
    else $error("standby outputs wrong");
  a_standby_pin_n_exit: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == smsc_pkg::SMSC_HWSTBY && standby_pin_n_n_s && !res_n_s
    |=> state_q == smsc_pkg::SMSC_RESET) else $error("standby exit wrong");
  a_rst_exc: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == smsc_pkg::SMSC_RSTEX && standby_pin_n_n_s |=> state_q == smsc_pkg::SMSC_RUN ##1 cpu_run)
    else $error("reset exception path wrong");
  a_stop_apply: assert property (@(posedge hclk) disable iff (!hresetn)
    !in_reset && !cpu_bus_busy && !ph_q && state_q == smsc_pkg::SMSC_RUN ##1
    state_q == smsc_pkg::SMSC_RUN |=> periph_clk_en == ~$past(mstop_req_q, 2))
    else $error("stop bits not applied");
  a_acs_tmr8: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == smsc_pkg::SMSC_ACSTOP && standby_pin_n_n_s |=> periph_clk_en[15:1] == 15'h0000)
    else $error("all-stop leaves module running");
  a_acs_block: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == smsc_pkg::SMSC_ACSTOP && !nmi_s && wake_is_dtc_source && standby_pin_n_n_s && res_n_s
    |=> state_q == smsc_pkg::SMSC_ACSTOP) else $error("blocked wake left all-stop");
  a_clk_hiz: assert property (@(posedge hclk) disable iff (!hresetn)
    !syscfg_q[smsc_pkg::BIT_DDR] |=> !clk_pin_oe) else $error("clock pin driven");
  a_clk_high: assert property (@(posedge hclk) disable iff (!hresetn)
    clock_out_stop_bit_act_q && syscfg_q[smsc_pkg::BIT_DDR] && state_q != smsc_pkg::SMSC_HWSTBY
    |=> clk_pin_o && clk_pin_oe) else $error("clock pin not high");
  a_reset_vals: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == smsc_pkg::SMSC_RESET |=> mstop_req_q == smsc_pkg::MSTOP_RST)
    else $error("reset stop value wrong");

  c_acs: cover property (@(posedge hclk) disable iff (!hresetn)
    state_q == smsc_pkg::SMSC_ACSTOP ##1 state_q == smsc_pkg::SMSC_RUN);
  c_hw_exit: cover property (@(posedge hclk) disable iff (!hresetn)
    state_q == smsc_pkg::SMSC_RESET ##1 state_q == smsc_pkg::SMSC_RSTEX);
  c_sleep: cover property (@(posedge hclk) disable iff (!hresetn)
    state_q == smsc_pkg::SMSC_SLEEP);
endmodule : smsc_ctrl

/* File: smsc_pkg.sv */
// package: constants, states and carriers of the standby / module-stop sequencer
package smsc_pkg;
  localparam int unsigned CLK_MHZ = 200;
  // register byte offsets
  localparam logic [7:0] OFS_MSTOP  = 8'h00;
  localparam logic [7:0] OFS_SYSCFG = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  // system config bit positions
  localparam int unsigned BIT_ALL_CLOCKS_STOP_ENABLE  = 0;
  localparam int unsigned BIT_SOFT_STANDBY_SELECT  = 1;
  localparam int unsigned BIT_CLOCK_OUT_STOP_BIT = 2;
  localparam int unsigned BIT_DDR   = 3;
  localparam int unsigned BIT_RAM_ENABLE_BIT  = 4;
  // module stop field
  localparam int unsigned NMOD = 16;
  localparam int unsigned BIT_TMR8 = 0;
  localparam int unsigned BIT_XFER_LO = 12;
  localparam int unsigned BIT_XFER_HI = 14;
  localparam int unsigned BIT_SCI = 5;
  // values after reset: all stopped except transfer engines 14..12
  localparam logic [15:0] MSTOP_RST  = 16'h8FFF;
  localparam logic [15:0] MSTOP_ALL  = 16'hFFFF;
  localparam logic [15:0] MSTOP_NT8  = 16'hFFFE;
  localparam logic [4:0]  SYSCFG_RST = 5'h10;
  // oscillator start count, time in ns
  localparam int unsigned OSC_START_NS = 1000;
  localparam int unsigned OSC_CYC = (OSC_START_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    SMSC_HWSTBY = 3'b000,
    SMSC_RESET  = 3'b001,
    SMSC_RSTEX  = 3'b010,
    SMSC_RUN    = 3'b011,
    SMSC_SLEEP  = 3'b100,
    SMSC_ACSTOP = 3'b101,
    SMSC_SWSTBY = 3'b110
  } smsc_state_t;

  typedef struct packed {
    logic nmi;
    logic ext_irq;
    logic tmr8_irq;
    logic wdt_irq;
  } smsc_wake_t;

  typedef struct packed {
    logic o;
    logic oe;
  } smsc_pin_t;
endpackage : smsc_pkg

/* File: smsc_sync.sv */
// two-flop synchroniser for asynchronous pin levels
module smsc_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= INIT;
      q      <= INIT;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : smsc_sync

/* File: smsc_host_model.sv */
// partner: external system controller driving the standby, reset and mode pins
module smsc_host_model #(
  parameter logic [2:0] MODE = 3'b101
) (
  // clock
  input  wire logic  hclk,
  // pins
  output logic       standby_pin_n,
  output logic       reset_pin_n,
  output logic [2:0] op_mode_select_pins
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    standby_pin_n = 1'b0;
    reset_pin_n = 1'b0;
  end

  // mode pins never move, standby included
  assign op_mode_select_pins = MODE;

  // reset is still low when standby rises
  task release_standby;
    @(posedge hclk);
    standby_pin_n <= 1'b1;
  endtask : release_standby

  // reset stays low for the whole oscillator start time, plus sync margin
  task release_reset;
    repeat (smsc_pkg::OSC_CYC + 8) @(posedge hclk);
    reset_pin_n <= 1'b1;
  endtask : release_reset

  task enter_standby;
    @(posedge hclk);
    reset_pin_n <= 1'b0;
    @(posedge hclk);
    standby_pin_n <= 1'b0;
  endtask : enter_standby
endmodule : smsc_host_model

/* File: tb_standby_module_stop_ctrl.sv */
// testbench: standby, module stop, all-stop and clock pin control
module tb_standby_module_stop_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize, op_mode_select_pins, xfer_engine_active, op_mode_latched;
  logic [31:0] hwdata, hrdata;
  logic        standby_pin_n, reset_pin_n, nmi_pin, sleep_req, irq_enabled;
  logic        irq_masked_but_nmi, wake_is_dtc_source, tmr8_irq, wdt_irq, cpu_bus_busy;
  logic [15:0] ext_interrupt_pins, periph_clk_en, periph_rst, periph_access_en;
  logic        chip_reset, osc_enable, reset_exc_start, cpu_run, wake_exc_start;
  logic        ports_hiz, bus_io_stop, ram_enable_bit, clk_pin_o, clk_pin_oe;
  int          n_errors, samples_checked;

  assign hready = hreadyout;

  smsc_ctrl dut_u (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .standby_pin_n, .reset_pin_n, .op_mode_select_pins, .nmi_pin,
    .ext_interrupt_pins, .sleep_req, .irq_enabled, .irq_masked_but_nmi, .wake_is_dtc_source,
    .tmr8_irq, .wdt_irq, .cpu_bus_busy, .xfer_engine_active, .periph_clk_en, .periph_rst,
    .periph_access_en, .chip_reset, .osc_enable, .reset_exc_start, .cpu_run, .wake_exc_start,
    .ports_hiz, .bus_io_stop, .ram_enable_bit, .op_mode_latched, .clk_pin_o, .clk_pin_oe
  );

  smsc_host_model u_host (.hclk, .standby_pin_n, .reset_pin_n, .op_mode_select_pins);

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  task end_of_test;
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc

  // one edge, then wait on hready with a bound
  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1 && n < 50) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 50) n_errors++;
  endtask : wait_ready

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    wait_ready;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready;
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0000_0000, r);
    check(r, exp);
  endtask : rd

  // counts changes of the clock pin over eight edges
  task automatic toggles(output int tg);
    logic p;
    tg = 0;
    p = clk_pin_o;
    repeat (8) begin
      @(posedge hclk);
      if (clk_pin_o !== p) tg++;
      p = clk_pin_o;
    end
  endtask : toggles

  task automatic pulses(input bit wake, output int n);
    n = 0;
    repeat (20) begin
      @(posedge hclk);
      if ((wake ? wake_exc_start : reset_exc_start) === 1'b1) n++;
    end
  endtask : pulses

  task automatic sleep_pulse;
    sleep_req <= 1'b1;
    cyc(1);
    sleep_req <= 1'b0;
    cyc(4);
  endtask : sleep_pulse

  task automatic t_reset_values;
    rd(smsc_pkg::OFS_MSTOP, 32'h0000_8FFF);
    rd(smsc_pkg::OFS_SYSCFG, 32'h0000_0010);
    rd(smsc_pkg::OFS_STATUS, 32'h0003_8FFF);
    rd(8'h0C, 32'h0000_0000);
    check({16'h0000, periph_clk_en}, 32'h0000_7000);
    check({31'h0, hresp}, 32'h0000_0000);
    check({31'h0, hreadyout}, 32'h0000_0001);
    check({31'h0, ram_enable_bit}, 32'h0000_0001);
  endtask : t_reset_values

  task automatic t_module_stop;
    cpu_bus_busy <= 1'b1;
    wr(smsc_pkg::OFS_MSTOP, 32'h0000_8FDF);
    cyc(4);
    check({16'h0000, periph_clk_en}, 32'h0000_7000);
    cpu_bus_busy <= 1'b0;
    cyc(4);
    check({16'h0000, periph_clk_en}, 32'h0000_7020);
    check({16'h0000, periph_access_en}, 32'h0000_7020);
    check({16'h0000, periph_rst}, 32'h0000_0000);
    // serial interface stops again: clock gated and its reset asserted
    wr(smsc_pkg::OFS_MSTOP, 32'h0000_8FFF);
    cyc(4);
    check({16'h0000, periph_clk_en}, 32'h0000_7000);
    check({16'h0000, periph_rst}, 32'h0000_0020);
  endtask : t_module_stop

  task automatic t_engine_refuse;
    xfer_engine_active <= 3'b001;
    wr(smsc_pkg::OFS_MSTOP, 32'h0000_9FFF);
    cyc(4);
    check({16'h0000, periph_clk_en}, 32'h0000_7000);
    xfer_engine_active <= 3'b000;
    wr(smsc_pkg::OFS_MSTOP, 32'h0000_9FFF);
    cyc(4);
    check({16'h0000, periph_clk_en}, 32'h0000_6000);
    wr(smsc_pkg::OFS_MSTOP, 32'h0000_8FFF);
  endtask : t_engine_refuse

  task automatic t_clock_pin;
    int tg;
    cyc(3);
    check({31'h0, clk_pin_oe}, 32'h0000_0000);
    wr(smsc_pkg::OFS_SYSCFG, 32'h0000_0018);
    cyc(4);
    toggles(tg);
    check(tg, 8);
    check({31'h0, clk_pin_oe}, 32'h0000_0001);
    wr(smsc_pkg::OFS_SYSCFG, 32'h0000_001C);
    cyc(4);
    toggles(tg);
    check(tg, 0);
    check({31'h0, clk_pin_o}, 32'h0000_0001);
    wr(smsc_pkg::OFS_SYSCFG, 32'h0000_0018);
  endtask : t_clock_pin

  task automatic t_sleep;
    int tg;
    sleep_pulse;
    rd(smsc_pkg::OFS_STATUS, 32'h0004_8FFF);
    ext_interrupt_pins <= 16'h0008;
    cyc(8);
    ext_interrupt_pins <= 16'h0000;
    rd(smsc_pkg::OFS_STATUS, 32'h0003_8FFF);
    // standby select set: sleep goes to software standby instead
    wr(smsc_pkg::OFS_SYSCFG, 32'h0000_001A);
    sleep_pulse;
    toggles(tg);
    check(tg, 0);
    check({30'h0, clk_pin_oe, clk_pin_o}, 32'h0000_0003);
    rd(smsc_pkg::OFS_STATUS, 32'h0006_8FFF);
    nmi_pin <= 1'b1;
    cyc(8);
    nmi_pin <= 1'b0;
    rd(smsc_pkg::OFS_STATUS, 32'h0003_8FFF);
    wr(smsc_pkg::OFS_SYSCFG, 32'h0000_0018);
  endtask : t_sleep

  task automatic t_all_stop;
    int tg;
    wr(smsc_pkg::OFS_MSTOP, 32'h0000_FFFE);
    wr(smsc_pkg::OFS_SYSCFG, 32'h0000_0019);
    sleep_pulse;
    check({31'h0, bus_io_stop}, 32'h0000_0001);
    check({16'h0000, periph_clk_en}, 32'h0000_0001);
    toggles(tg);
    check(tg, 8);
    wake_is_dtc_source <= 1'b1;
    tmr8_irq <= 1'b1;
    cyc(8);
    check({31'h0, bus_io_stop}, 32'h0000_0001);
    wake_is_dtc_source <= 1'b0;
    pulses(1'b1, tg);
    check(tg, 1);
    tmr8_irq <= 1'b0;
    rd(smsc_pkg::OFS_STATUS, 32'h0003_FFFE);
    wr(smsc_pkg::OFS_MSTOP, 32'h0000_8FFF);
    wr(smsc_pkg::OFS_SYSCFG, 32'h0000_0008);
  endtask : t_all_stop

  task automatic t_hw_standby;
    int n;
    wr(smsc_pkg::OFS_SYSCFG, 32'h0000_0008);
    cyc(2);
    check({31'h0, ram_enable_bit}, 32'h0000_0000);
    u_host.enter_standby();
    for (n = 0; n < 20 && ports_hiz !== 1'b1; n++) cyc(1);
    check({31'h0, ports_hiz}, 32'h0000_0001);
    check({15'h0, chip_reset, periph_rst}, 32'h0001_FFFF);
    check({16'h0000, periph_clk_en}, 32'h0000_0000);
    check({31'h0, clk_pin_oe}, 32'h0000_0000);
    check({29'h0, op_mode_latched}, 32'h0000_0005);
    wr(smsc_pkg::OFS_MSTOP, 32'h0000_0000);
    u_host.release_standby();
    cyc(10);
    check({30'h0, chip_reset, osc_enable}, 32'h0000_0003);
    rd(smsc_pkg::OFS_STATUS, 32'h0001_8FFF);
    u_host.release_reset();
    pulses(1'b0, n);
    check(n, 1);
    check({31'h0, cpu_run}, 32'h0000_0001);
    rd(smsc_pkg::OFS_MSTOP, 32'h0000_8FFF);
  endtask : t_hw_standby

  initial begin
    repeat (5000) @(posedge hclk);
    n_errors++;
    end_of_test;
  end

  initial begin
    int n;
    hresetn = 1'b0;
    {hsel, hwrite, sleep_req, nmi_pin, tmr8_irq, wdt_irq, cpu_bus_busy} = '0;
    {irq_masked_but_nmi, wake_is_dtc_source} = '0;
    irq_enabled = 1'b1;
    haddr = 8'h00;
    htrans = 2'b00;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    ext_interrupt_pins = 16'h0000;
    xfer_engine_active = 3'b000;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    u_host.release_standby();
    u_host.release_reset();
    for (n = 0; n < 20 && cpu_run !== 1'b1; n++) cyc(1);
    t_reset_values;
    t_module_stop;
    t_engine_refuse;
    t_clock_pin;
    t_sleep;
    t_all_stop;
    t_hw_standby;
    end_of_test;
  end
endmodule : tb_standby_module_stop_ctrl
